// >>> src/dpmc_power_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE_01) ultra dma renames ready and strobe lines
// (RULE_02) soft reset, standby, sleep commands unload heads
// (RULE_03) adaptive idle timeout also unloads heads
// (RULE_04) active while command, flush or read-ahead
// (RULE_05) performance idle serves commands without delay
// (RULE_06) command arrival/completion toggles active and idle
// (RULE_07) active idle answers within 40 ms
// (RULE_08) low power idle answers within 40 ms
// (RULE_09) standby stops spindle, keeps command interface
// (RULE_10) host-programmed inactivity timer enters standby
// (RULE_11) command in standby spins up, then executes
// (RULE_12) sleep only by explicit command
// (RULE_13) only reset leaves sleep
// (RULE_14) host tri-states lines while drive unpowered
// (RULE_15) six-state mode; command returns to active
module dpmc_power_ctrl #(
	parameter int unsigned WAKE_IDLE_CYC = dpmc_pkg::DPMC_WAKE_IDLE_CYC,
	parameter int unsigned SPINUP_CYC    = dpmc_pkg::DPMC_SPINUP_CYC,
	parameter int unsigned SETTLE_CYC    = dpmc_pkg::DPMC_SETTLE_CYC,
	parameter int unsigned TICK_CYC      = dpmc_pkg::DPMC_TICK_CYC,
	parameter int unsigned ADAPT_CYC     = dpmc_pkg::DPMC_SETTLE_CYC
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic        cmd_done_i,
	input  wire logic        soft_reset_i,
	input  wire logic        flush_busy_i,
	input  wire logic        readahead_busy_i,
	input  wire logic        group_done_i,
	input  wire logic        lp_select_i,
	input  wire logic        stby_load_i,
	input  wire logic [15:0] stby_ticks_i,
	input  wire logic        udma_i,
	input  wire logic        udma_read_i,
	input  wire logic        host_rd_n_i,
	input  wire logic        host_wr_n_i,
	input  wire logic        dev_ready_i,
	input  wire logic        dev_strobe_i,
	output logic             cmd_exec_o,
	output logic             cmd_sleep_drop_o,
	output logic             heads_unload_o,
	output logic             spindle_on_o,
	output logic             elec_on_o,
	output logic             if_on_o,
	output logic [2:0]       mode_o,
	output logic             iordy_o,
	output logic             host_strobe_o,
	output logic             host_rdy_n_o,
	output logic             udma_stop_o
);
	dpmc_pkg::dpmc_mode_t mode_r;
	dpmc_pkg::dpmc_mode_t mode_nxt;
	dpmc_wake_if          wk ();

	logic [15:0] stby_reload_r;
	logic [15:0] stby_cnt_r;
	logic [31:0] tick_cnt_r;
	logic [31:0] adapt_cnt_r;
	logic        pend_r;
	logic [7:0]  pend_code_r;
	logic        cmd_busy_r;
	logic        stby_expire;
	logic        adapt_expire;
	logic        busy_any;
	logic        new_cmd;

	function automatic logic is_sleep_cmd(input logic [7:0] c);
		is_sleep_cmd = (c == dpmc_pkg::DPMC_CMD_SLEEP) || (c == dpmc_pkg::DPMC_CMD_SLEEP_ALT);
	endfunction : is_sleep_cmd

	function automatic logic is_unload_cmd(input logic [7:0] c);
		is_unload_cmd = (c == dpmc_pkg::DPMC_CMD_STANDBY) || (c == dpmc_pkg::DPMC_CMD_STANDBY_ALT)
			|| (c == dpmc_pkg::DPMC_CMD_STBY_IMM) || (c == dpmc_pkg::DPMC_CMD_STBY_IMM_ALT)
			|| is_sleep_cmd(c);
	endfunction : is_unload_cmd

	function automatic logic [2:0] mode_code(input dpmc_pkg::dpmc_mode_t m);
		case (m)
			dpmc_pkg::DPMC_ACTIVE:    mode_code = dpmc_pkg::DPMC_CODE_ACTIVE;
			dpmc_pkg::DPMC_PERF_IDLE: mode_code = dpmc_pkg::DPMC_CODE_PERF_IDLE;
			dpmc_pkg::DPMC_ACT_IDLE:  mode_code = dpmc_pkg::DPMC_CODE_ACT_IDLE;
			dpmc_pkg::DPMC_LP_IDLE:   mode_code = dpmc_pkg::DPMC_CODE_LP_IDLE;
			dpmc_pkg::DPMC_STANDBY:   mode_code = dpmc_pkg::DPMC_CODE_STANDBY;
			dpmc_pkg::DPMC_SLEEP:     mode_code = dpmc_pkg::DPMC_CODE_SLEEP;
			default:                  mode_code = dpmc_pkg::DPMC_CODE_ACTIVE;
		endcase
	endfunction : mode_code

	dpmc_wake_timer u_wake (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.wk        (wk.tmr)
	);

	// a command in sleep is dropped; only reset wakes the drive
	assign new_cmd  = cmd_valid_i && (mode_r != dpmc_pkg::DPMC_SLEEP); // RULE_13
	assign busy_any = cmd_busy_r || flush_busy_i || readahead_busy_i; // RULE_04
	assign stby_expire  = (stby_reload_r != 16'h0) && (stby_cnt_r == 16'h0) && !busy_any;
	assign adapt_expire = (adapt_cnt_r == 32'h0);

	// wake delay chosen from the mode the command found
	always_comb begin
		wk.start  = 1'b0;
		wk.cycles = 32'h0;
		if (new_cmd && !pend_r && !wk.busy) begin
			case (mode_r)
				dpmc_pkg::DPMC_ACT_IDLE,
				dpmc_pkg::DPMC_LP_IDLE: begin
					wk.start  = 1'b1;
					wk.cycles = WAKE_IDLE_CYC; // RULE_07 RULE_08
				end
				dpmc_pkg::DPMC_STANDBY: begin
					wk.start  = 1'b1;
					wk.cycles = SPINUP_CYC; // RULE_11
				end
				default: begin
					wk.start  = 1'b0;
					wk.cycles = 32'h0;
				end
			endcase
		end
	end

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			dpmc_pkg::DPMC_ACTIVE: begin
				if (cmd_done_i && cmd_busy_r && is_sleep_cmd(pend_code_r))
					mode_nxt = dpmc_pkg::DPMC_SLEEP; // RULE_12
				else if (cmd_done_i && cmd_busy_r && is_unload_cmd(pend_code_r))
					mode_nxt = dpmc_pkg::DPMC_STANDBY; // RULE_02
				else if (!busy_any && !pend_r)
					mode_nxt = dpmc_pkg::DPMC_PERF_IDLE; // RULE_06
			end
			dpmc_pkg::DPMC_PERF_IDLE: begin
				if (new_cmd || busy_any)
					mode_nxt = dpmc_pkg::DPMC_ACTIVE; // RULE_05 RULE_06
				else if (stby_expire)
					mode_nxt = dpmc_pkg::DPMC_STANDBY; // RULE_10
				else if (group_done_i || adapt_expire)
					mode_nxt = lp_select_i ? dpmc_pkg::DPMC_LP_IDLE : dpmc_pkg::DPMC_ACT_IDLE; // RULE_03
			end
			dpmc_pkg::DPMC_ACT_IDLE,
			dpmc_pkg::DPMC_LP_IDLE,
			dpmc_pkg::DPMC_STANDBY: begin
				if (wk.done)
					mode_nxt = dpmc_pkg::DPMC_ACTIVE; // RULE_15
				else if (stby_expire && mode_r != dpmc_pkg::DPMC_STANDBY && !pend_r)
					mode_nxt = dpmc_pkg::DPMC_STANDBY; // RULE_10
			end
			dpmc_pkg::DPMC_SLEEP: begin
				mode_nxt = dpmc_pkg::DPMC_SLEEP; // RULE_13
			end
			default: mode_nxt = dpmc_pkg::DPMC_ACTIVE;
		endcase
		if (soft_reset_i)
			mode_nxt = dpmc_pkg::DPMC_PERF_IDLE; // RULE_13
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			mode_r <= dpmc_pkg::DPMC_ACTIVE;
		else
			mode_r <= mode_nxt;
	end

	// command capture; held while waking, issued once active
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_r      <= 1'b0;
			pend_code_r <= 8'h0;
			cmd_busy_r  <= 1'b0;
			cmd_exec_o  <= 1'b0;
		end else begin
			cmd_exec_o <= 1'b0;
			if (soft_reset_i) begin
				pend_r     <= 1'b0;
				cmd_busy_r <= 1'b0;
			end else if (new_cmd && !pend_r && !cmd_busy_r) begin
				pend_code_r <= cmd_code_i;
				pend_r      <= 1'b1;
			end else if (pend_r && mode_r == dpmc_pkg::DPMC_ACTIVE) begin
				pend_r     <= 1'b0;
				cmd_busy_r <= 1'b1;
				cmd_exec_o <= 1'b1; // RULE_05
			end else if (cmd_busy_r && cmd_done_i) begin
				cmd_busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cmd_sleep_drop_o <= 1'b0;
		else
			cmd_sleep_drop_o <= cmd_valid_i && (mode_r == dpmc_pkg::DPMC_SLEEP); // RULE_13
	end

	// standby timer counts in ticks only while no command is processed
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stby_reload_r <= 16'h0;
			stby_cnt_r    <= 16'h0;
			tick_cnt_r    <= 32'h0;
		end else begin
			if (stby_load_i)
				stby_reload_r <= stby_ticks_i; // RULE_10
			if (stby_load_i || busy_any || pend_r || mode_r == dpmc_pkg::DPMC_STANDBY) begin
				stby_cnt_r <= stby_load_i ? stby_ticks_i : stby_reload_r;
				tick_cnt_r <= 32'h0;
			end else if (stby_cnt_r != 16'h0) begin
				if (tick_cnt_r >= TICK_CYC - 1) begin
					tick_cnt_r <= 32'h0;
					stby_cnt_r <= stby_cnt_r - 16'h1; // RULE_10
				end else begin
					tick_cnt_r <= tick_cnt_r + 32'h1;
				end
			end
		end
	end

	// short inactivity window before the adaptive idle step
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			adapt_cnt_r <= 32'h0;
		else if (mode_r != dpmc_pkg::DPMC_PERF_IDLE)
			adapt_cnt_r <= ADAPT_CYC;
		else if (adapt_cnt_r != 32'h0)
			adapt_cnt_r <= adapt_cnt_r - 32'h1; // RULE_03
	end

	// power outputs follow the mode
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spindle_on_o   <= 1'b1;
			elec_on_o      <= 1'b1;
			if_on_o        <= 1'b1;
			heads_unload_o <= 1'b0;
			mode_o         <= dpmc_pkg::DPMC_CODE_ACTIVE;
		end else begin
			mode_o       <= mode_code(mode_nxt);
			spindle_on_o <= !(mode_nxt inside {dpmc_pkg::DPMC_STANDBY, dpmc_pkg::DPMC_SLEEP}); // RULE_09
			elec_on_o    <= mode_nxt inside {dpmc_pkg::DPMC_ACTIVE, dpmc_pkg::DPMC_PERF_IDLE};
			if_on_o      <= (mode_nxt != dpmc_pkg::DPMC_SLEEP); // RULE_09
			heads_unload_o <= soft_reset_i || (mode_nxt inside {dpmc_pkg::DPMC_ACT_IDLE,
				dpmc_pkg::DPMC_LP_IDLE, dpmc_pkg::DPMC_STANDBY, dpmc_pkg::DPMC_SLEEP}); // RULE_02 RULE_03
		end
	end

	// ultra dma reuse of the ready and strobe lines
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			iordy_o       <= 1'b1;
			host_strobe_o <= 1'b1;
			host_rdy_n_o  <= 1'b1;
			udma_stop_o   <= 1'b0;
		end else if (udma_i) begin
			// stop is active high: the write line level passes as is
			udma_stop_o   <= host_wr_n_i; // RULE_01
			host_strobe_o <= udma_read_i ? 1'b1 : host_rd_n_i; // RULE_01
			host_rdy_n_o  <= udma_read_i ? host_rd_n_i : 1'b1; // RULE_01
			iordy_o       <= udma_read_i ? dev_strobe_i : !dev_ready_i; // RULE_01
		end else begin
			udma_stop_o   <= 1'b0;
			host_strobe_o <= 1'b1;
			host_rdy_n_o  <= 1'b1;
			iordy_o       <= dev_ready_i;
		end
	end
endmodule : dpmc_power_ctrl
`default_nettype wire

// >>> pkg/dpmc_pkg.sv
package dpmc_pkg;
	// power modes, one-hot
	typedef enum logic [5:0] {
		DPMC_ACTIVE    = 6'h01,
		DPMC_PERF_IDLE = 6'h02,
		DPMC_ACT_IDLE  = 6'h04,
		DPMC_LP_IDLE   = 6'h08,
		DPMC_STANDBY   = 6'h10,
		DPMC_SLEEP     = 6'h20
	} dpmc_mode_t;

	// mode codes shown on the status port
	localparam logic [2:0] DPMC_CODE_ACTIVE    = 3'h0;
	localparam logic [2:0] DPMC_CODE_PERF_IDLE = 3'h1;
	localparam logic [2:0] DPMC_CODE_ACT_IDLE  = 3'h2;
	localparam logic [2:0] DPMC_CODE_LP_IDLE   = 3'h3;
	localparam logic [2:0] DPMC_CODE_STANDBY   = 3'h4;
	localparam logic [2:0] DPMC_CODE_SLEEP     = 3'h5;

	// command classes decoded from the command byte
	localparam logic [7:0] DPMC_CMD_STANDBY     = 8'he2;
	localparam logic [7:0] DPMC_CMD_STANDBY_ALT = 8'h96;
	localparam logic [7:0] DPMC_CMD_STBY_IMM    = 8'he0;
	localparam logic [7:0] DPMC_CMD_STBY_IMM_ALT= 8'h94;
	localparam logic [7:0] DPMC_CMD_SLEEP       = 8'he6;
	localparam logic [7:0] DPMC_CMD_SLEEP_ALT   = 8'h99;

	// timing
	localparam int DPMC_CLK_MHZ        = 100;
	localparam int DPMC_WAKE_IDLE_MS   = 40;
	localparam int DPMC_WAKE_IDLE_CYC  = DPMC_WAKE_IDLE_MS * 1000 * DPMC_CLK_MHZ;
	localparam int DPMC_SPINUP_MS      = 2000;
	localparam int DPMC_SPINUP_CYC     = DPMC_SPINUP_MS * 1000 * DPMC_CLK_MHZ;
	localparam int DPMC_SETTLE_MS      = 10;
	localparam int DPMC_SETTLE_CYC     = DPMC_SETTLE_MS * 1000 * DPMC_CLK_MHZ;
	localparam int DPMC_STBY_TICKS_W   = 16;
	localparam int DPMC_TICK_MS        = 5000;
	localparam int DPMC_TICK_CYC       = DPMC_TICK_MS * 1000 * DPMC_CLK_MHZ;
endpackage : dpmc_pkg

// >>> pkg/dpmc_wake_if.sv
`timescale 1ns/1ps
`default_nettype none
// delay request and done between controller and its wake timer
interface dpmc_wake_if;
	logic        start;
	logic [31:0] cycles;
	logic        busy;
	logic        done;
	modport ctrl (output start, output cycles, input busy, input done);
	modport tmr  (input start, input cycles, output busy, output done);
endinterface : dpmc_wake_if
`default_nettype wire

// >>> src/dpmc_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dpmc_wake_timer (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	dpmc_wake_if.tmr         wk
);
	logic [31:0] cnt_r;
	logic        busy_r;
	logic        done_r;

	assign wk.busy = busy_r;
	assign wk.done = done_r;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r  <= 32'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (wk.start) begin
				cnt_r  <= (wk.cycles > 32'h1) ? wk.cycles - 32'h1 : 32'h0;
				busy_r <= (wk.cycles > 32'h1);
				done_r <= (wk.cycles <= 32'h1);
			end else if (busy_r) begin
				if (cnt_r <= 32'h1) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
					cnt_r  <= 32'h0;
				end else begin
					cnt_r <= cnt_r - 32'h1;
				end
			end
		end
	end
endmodule : dpmc_wake_timer
`default_nettype wire

// >>> tb/dpmc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dpmc_properties #(
	parameter int WAKE_IDLE_CYC = 8,
	parameter int SPINUP_CYC    = 20
) (
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic       cmd_valid_i,
	input wire logic       cmd_done_i,
	input wire logic       soft_reset_i,
	input wire logic       flush_busy_i,
	input wire logic       udma_i,
	input wire logic       cmd_exec_o,
	input wire logic       cmd_sleep_drop_o,
	input wire logic       heads_unload_o,
	input wire logic       spindle_on_o,
	input wire logic       if_on_o,
	input wire logic [2:0] mode_o,
	input wire logic       udma_stop_o
);
	localparam int WMAX = WAKE_IDLE_CYC + 4;
	localparam int SMAX = SPINUP_CYC + 4;
	wire logic act = mode_o == dpmc_pkg::DPMC_CODE_ACTIVE;
	wire logic pid = mode_o == dpmc_pkg::DPMC_CODE_PERF_IDLE;
	wire logic idl = mode_o == dpmc_pkg::DPMC_CODE_ACT_IDLE || mode_o == dpmc_pkg::DPMC_CODE_LP_IDLE;
	wire logic stb = mode_o == dpmc_pkg::DPMC_CODE_STANDBY;
	wire logic slp = mode_o == dpmc_pkg::DPMC_CODE_SLEEP;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_perf_req; pid && cmd_valid_i && !soft_reset_i; endsequence
	sequence s_enter_sleep; !slp ##1 slp; endsequence
	property p_udma_stop; !udma_i |=> !udma_stop_o; endproperty
	property p_unload; slp && $past(slp) |-> heads_unload_o; endproperty
	property p_soft; soft_reset_i |-> ##[1:3] heads_unload_o; endproperty
	property p_flush; pid && flush_busy_i |-> ##[1:3] act; endproperty
	property p_perf; s_perf_req |-> ##2 cmd_exec_o; endproperty
	property p_done; act && cmd_done_i && !flush_busy_i |-> ##[1:3] !act; endproperty
	property p_wake; idl && cmd_valid_i |-> ##[3:WMAX] cmd_exec_o; endproperty
	property p_stby; stb && $past(stb) |-> !spindle_on_o && if_on_o; endproperty
	property p_spin; stb && cmd_valid_i |-> ##[3:SMAX] cmd_exec_o; endproperty
	property p_sleep_in; s_enter_sleep |-> $past(cmd_done_i) || $past(cmd_done_i, 2) || $past(cmd_done_i, 3);
	endproperty
	property p_sleep_hold; slp && cmd_valid_i && !soft_reset_i |=> cmd_sleep_drop_o && !cmd_exec_o && slp;
	endproperty
	property p_back_active; (idl || stb) && cmd_valid_i |-> ##[1:SMAX] act; endproperty
	a_udma_stop: assert property (p_udma_stop) else $error("stop raised outside ultra dma");
	a_unload: assert property (p_unload) else $error("heads loaded while asleep");
	a_soft: assert property (p_soft) else $error("soft reset left heads loaded");
	a_flush: assert property (p_flush) else $error("flush not counted as active");
	a_perf: assert property (p_perf) else $error("perf idle command delayed");
	a_done: assert property (p_done) else $error("active held after completion");
	a_wake: assert property (p_wake) else $error("idle wake out of bounds");
	a_stby: assert property (p_stby) else $error("standby power wrong");
	a_spin: assert property (p_spin) else $error("standby spin-up out of bounds");
	a_sleep_in: assert property (p_sleep_in) else $error("sleep without command");
	a_sleep_hold: assert property (p_sleep_hold) else $error("command woke sleep");
	a_back_active: assert property (p_back_active) else $error("command did not reach active");
endmodule : dpmc_properties
`default_nettype wire

// >>> tb/dpmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpmc_host_model (
	input  wire logic        sys_clk_i,
	input  wire logic        cmd_exec_i,
	output var  logic        cmd_valid_o,
	output var  logic [7:0]  cmd_code_o,
	output var  logic        cmd_done_o,
	output var  logic        stby_load_o,
	output var  logic [15:0] stby_ticks_o
);
	initial begin
		{cmd_valid_o, cmd_done_o, stby_load_o} = 3'h0;
		cmd_code_o = 8'h00;
		stby_ticks_o = 16'h0000;
	end
	// lat is edges from take to exec, 0 when never executed
	task automatic send(input logic [7:0] c, output int lat);
		@(negedge sys_clk_i);
		cmd_valid_o = 1'b1;
		cmd_code_o = c;
		@(negedge sys_clk_i);
		cmd_valid_o = 1'b0;
		cmd_code_o = ~c;
		lat = 0;
		for (int i = 1; i < 100 && lat == 0; i++) begin
			@(posedge sys_clk_i);
			#1;
			if (cmd_exec_i === 1'b1) lat = i;
		end
		@(negedge sys_clk_i);
	endtask : send
	task automatic finish_cmd;
		@(negedge sys_clk_i);
		cmd_done_o = 1'b1;
		@(negedge sys_clk_i);
		cmd_done_o = 1'b0;
	endtask : finish_cmd
	task automatic load(input logic [15:0] t);
		@(negedge sys_clk_i);
		stby_load_o = 1'b1;
		stby_ticks_o = t;
		@(negedge sys_clk_i);
		stby_load_o = 1'b0;
	endtask : load
endmodule : dpmc_host_model
`default_nettype wire

// >>> tb/tb_disk_drive_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_disk_drive_power_mode_control;
	localparam int WK = 8, SP = 20, TK = 10, AD = 30;
	localparam logic [2:0] ACT = 3'h0, PID = 3'h1, AID = 3'h2, LID = 3'h3, STB = 3'h4, SLP = 3'h5;
	typedef struct packed {logic [7:0] code; logic [2:0] mode; logic unl;} dpmc_row_t;
	dpmc_row_t rows [7] = '{'{8'h20, PID, 1'b0}, '{8'hca, PID, 1'b0}, '{8'he2, STB, 1'b1}, '{8'h96, STB, 1'b1},
		'{8'he0, STB, 1'b1}, '{8'h94, STB, 1'b1}, '{8'hc4, PID, 1'b0}};
	logic [7:0] slp_codes [2] = '{8'he6, 8'h99};
	logic sys_clk_i, rst_n_i, soft_reset_i, flush_busy_i, readahead_busy_i, group_done_i, lp_select_i;
	logic udma_i, udma_read_i, host_rd_n_i, host_wr_n_i, dev_ready_i, dev_strobe_i;
	wire logic cmd_valid_i, cmd_done_i, stby_load_i;
	wire logic [7:0] cmd_code_i;
	wire logic [15:0] stby_ticks_i;
	logic cmd_exec_o, cmd_sleep_drop_o, heads_unload_o, spindle_on_o, elec_on_o, if_on_o;
	logic iordy_o, host_strobe_o, host_rdy_n_o, udma_stop_o;
	logic [2:0] mode_o;
	int bad_count = 0, comparisons = 0;
	dpmc_power_ctrl #(.WAKE_IDLE_CYC(WK), .SPINUP_CYC(SP), .SETTLE_CYC(4), .TICK_CYC(TK), .ADAPT_CYC(AD)) dut_u (.*);
	dpmc_host_model host_u (.sys_clk_i, .cmd_exec_i(cmd_exec_o), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
		.cmd_done_o(cmd_done_i), .stby_load_o(stby_load_i), .stby_ticks_o(stby_ticks_i));
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : cyc
	task automatic do_reset;
		rst_n_i = 1'b0;
		cyc(5);
		chk("rst_mode", ACT, mode_o);
		chk("rst_spin", 1, spindle_on_o);
		rst_n_i = 1'b1;
		cyc(3);
		chk("idle_mode", PID, mode_o);
	endtask : do_reset
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// whole run is near 600 cycles, so 10000 means a hang
	initial begin
		#100000;
		bad_count++;
		final_report();
	end
	initial begin
		int lat;
		logic [2:0] pm;
		{soft_reset_i, flush_busy_i, readahead_busy_i, group_done_i, lp_select_i, udma_i, udma_read_i} = 7'h00;
		{host_rd_n_i, host_wr_n_i, dev_ready_i, dev_strobe_i} = 4'hf;
		do_reset();
		pm = PID;
		foreach (rows[i]) begin
			host_u.send(rows[i].code, lat);
			if (pm == PID) chk("lat_perf", 1, lat);
			else chk("lat_spin", 1, lat >= 3 && lat <= SP + 4);
			host_u.finish_cmd();
			cyc(3);
			chk("row_mode", rows[i].mode, mode_o);
			if (rows[i].unl) chk("row_heads", 1, heads_unload_o);
			pm = rows[i].mode;
		end
		foreach (slp_codes[i]) begin
			host_u.send(slp_codes[i], lat);
			host_u.finish_cmd();
			cyc(3);
			chk("sleep_mode", SLP, mode_o);
			chk("sleep_heads", 1, heads_unload_o);
			host_u.send(8'h20, lat);
			chk("sleep_lat", 0, lat);
			chk("sleep_hold", SLP, mode_o);
			soft_reset_i = 1'b1;
			cyc(1);
			chk("soft_heads", 1, heads_unload_o);
			soft_reset_i = 1'b0;
			cyc(3);
			chk("wake_mode", PID, mode_o);
		end
		for (int k = 0; k < 2; k++) begin
			lp_select_i = k[0];
			group_done_i = 1'b1;
			cyc(1);
			group_done_i = 1'b0;
			cyc(3);
			chk("adapt_mode", k[0] ? LID : AID, mode_o);
			chk("adapt_elec", 0, elec_on_o);
			host_u.send(8'h30, lat);
			chk("wake_lat", 1, lat >= 3 && lat <= WK + 4);
			host_u.finish_cmd();
			cyc(3);
		end
		cyc(AD + 8);
		chk("inact_mode", LID, mode_o);
		host_u.send(8'h20, lat);
		host_u.finish_cmd();
		host_u.load(16'h0002);
		cyc(2 * TK + AD + 10);
		chk("stby_mode", STB, mode_o);
		chk("stby_spin", 0, spindle_on_o);
		chk("stby_if", 1, if_on_o);
		chk("stby_elec", 0, elec_on_o);
		host_u.send(8'h20, lat);
		chk("stby_lat", 1, lat >= 3 && lat <= SP + 4);
		host_u.finish_cmd();
		host_u.load(16'h0000);
		for (int k = 0; k < 2; k++) begin
			{readahead_busy_i, flush_busy_i} = k[0] ? 2'h2 : 2'h1;
			cyc(4);
			chk("busy_mode", ACT, mode_o);
			{readahead_busy_i, flush_busy_i} = 2'h0;
			cyc(4);
			chk("busy_end", PID, mode_o);
		end
		udma_i = 1'b1;
		for (int k = 0; k < 8; k++) begin
			{host_wr_n_i, host_rd_n_i, udma_read_i} = k[2:0];
			{dev_strobe_i, dev_ready_i} = {k[2] ^ k[1], ~k[1]};
			cyc(2);
			chk("udma_iordy", udma_read_i ? dev_strobe_i : !dev_ready_i, iordy_o);
			chk("udma_hstrobe", udma_read_i ? 1'b1 : host_rd_n_i, host_strobe_o);
			chk("udma_hrdy_n", udma_read_i ? host_rd_n_i : 1'b1, host_rdy_n_o);
			chk("udma_stop", host_wr_n_i, udma_stop_o);
		end
		udma_i = 1'b0;
		cyc(2);
		chk("stop_idle", 0, udma_stop_o);
		chk("conv_iordy", dev_ready_i, iordy_o);
		chk("conv_strobe", 1, host_strobe_o);
		chk("conv_rdy_n", 1, host_rdy_n_o);
		do_reset();
		final_report();
	end
endmodule : tb_disk_drive_power_mode_control
bind dpmc_power_ctrl dpmc_properties #(.WAKE_IDLE_CYC(WAKE_IDLE_CYC), .SPINUP_CYC(SPINUP_CYC)) chk_u (.*);
`default_nettype wire
